// >>> logic/lcd_panel_timing_controller.sv
// How it works
// - Memory clock is dot clock divided by four
// - Reset low halts and zeroes timing counters
// - Reset leaves programmable registers untouched
// - Host access only while chip select low
// - Fetch window high while reading display data
// - Display, blink, attribute, graphic and wide modes are pin OR register bit
// - Display enable high shows, low blanks
// - Blink attribute alternates every 32 frames
// - Graphic select high picks graphic mode
// - Wide select high doubles character width
// - Large screen graphic moves 16 bits per cycle
// - Large screen selects 8-bit panel interface
// - Dual select high drives dual-screen panel
// - Easy mode applies preset raster settings
// - Upper nibble carries single or upper data
// - Lower nibble idle single 4-bit, else data
// - Skew selects none, one, two characters
// - Low byte dots, high byte attributes/bitmap
// - 16-bit memory and 5-bit raster address
// - Line latch clock and data shift clock
// - First-line marker and AC drive outputs
// - Host bus three-state, driven for reads
`timescale 1ns/10ps
module lcd_panel_timing_controller (
   // Clock, reset, enable
   input  wire logic        CLK,
   input  wire logic        RESETN,
   input  wire logic        CE,
   // Host register port
   input  wire logic        CS_N,
   input  wire logic        REGISTER_SEL,
   input  wire logic        WR_STB,
   input  wire logic        RD_STB,
   input  wire logic [7:0]  HOST_DATA_IN,
   output logic      [7:0]  HOST_DATA_OUT,
   output logic             HOST_DATA_OE_N,
   // Display memory
   output logic      [15:0] DISPLAY_MEMORY_ADDR,
   output logic      [4:0]  RASTER_LINE_ADDR,
   input  wire logic [7:0]  CHAR_DOT_DATA,
   input  wire logic [7:0]  ATTRIBUTE_DATA,
   // Timing outputs
   output logic             MCLK_OUT,
   output logic             DISPLAY_FETCH_WINDOW,
   output logic             CURSOR_TIMING,
   // Mode pins
   input  wire logic        SKEW_SELECT_LO,
   input  wire logic        SKEW_SELECT_HI,
   input  wire logic        DISPLAY_ON,
   input  wire logic        BLINK_ALLOW,
   input  wire logic        ATTRIBUTE_ENABLE,
   input  wire logic        GRAPHIC_SELECT,
   input  wire logic        WIDE_SELECT,
   input  wire logic        LARGE_SCREEN_SELECT,
   input  wire logic        DUAL_SCREEN_SELECT,
   input  wire logic        EASY_MODE,
   // Panel drivers
   output logic      [3:0]  UPPER_PANEL_DATA,
   output logic      [3:0]  LOWER_PANEL_DATA,
   output logic             LINE_LATCH_CLOCK,
   output logic             DATA_SHIFT_CLOCK,
   output logic             FRAME_START_MARKER,
   output logic             AC_DRIVE
);

   // ==========================================================
   // Declarations
   // ==========================================================
   logic [1:0]  div_reg;          // Dot counter inside a memory cycle
   logic        tick;             // Last dot of a memory cycle
   logic [4:0]  index_reg;        // Address register
   logic [7:0]  htotal_reg;       // Programmable registers
   logic [7:0]  hdisp_reg;
   logic [7:0]  vtotal_reg;
   logic [7:0]  vdisp_reg;
   logic [4:0]  maxras_reg;
   logic [4:0]  cur_start_reg;
   logic [4:0]  cur_end_reg;
   logic [15:0] start_reg;
   logic [15:0] cur_addr_reg;
   lcd_timing_pkg::mode_t mode_reg;
   lcd_timing_pkg::mode_t mode_eff;   // Pins ORed with register
   logic [4:0]  maxras_eff;           // After easy-mode override
   logic [4:0]  cur_start_eff;
   logic [4:0]  cur_end_eff;
   logic [7:0]  vtotal_eff;
   logic [7:0]  h_reg;            // Character time in line
   logic [4:0]  ras_reg;          // Raster in row
   logic [7:0]  row_reg;          // Row in frame
   logic [15:0] ma_reg;           // Current memory address
   logic [15:0] ma_row_reg;       // Address of row start
   logic        wide_half_reg;    // Second half of a wide character
   logic        line_end;
   logic        row_end;
   logic        frame_end;
   lcd_timing_pkg::line_phase_t phase;
   logic        win_now;          // Undelayed fetch window
   logic        cur_now;          // Undelayed cursor
   logic [1:0]  win_dly_reg;      // Skew delay stages
   logic [1:0]  cur_dly_reg;
   logic        win_skew;
   logic        cur_skew;
   logic [4:0]  frame_cnt_reg;    // Frames within a blink phase
   logic        blink_phase_reg;  // High while blinking chars blank
   logic [7:0]  dots;             // Character pixels after attributes
   logic [15:0] load_word;        // Word queued for the panel
   logic [2:0]  load_count;       // Shifts needed for that word
   logic [15:0] sh_word_reg;
   logic [2:0]  sh_left_reg;
   logic        wide8;            // 8 bits per shift
   logic        read_ok;
   logic        write_ok;
   logic [7:0]  read_value;

   // ==========================================================
   // Memory-cycle clock
   // ==========================================================
   // Divide the dot clock by four; one period is one memory cycle
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         div_reg <= 2'h0;
      end else if (CE) begin
         div_reg <= div_reg + 2'h1;
      end
   end
   assign tick     = CE && (div_reg == lcd_timing_pkg::MCLK_LAST);
   assign MCLK_OUT = div_reg[lcd_timing_pkg::MCLK_BIT];

   // ==========================================================
   // Host register port
   // ==========================================================
   assign write_ok = CE && !CS_N && WR_STB;
   assign read_ok  = CE && !CS_N && RD_STB;

   // Registers have no reset so that reset leaves them alone
   always_ff @(posedge CLK) begin
      if (write_ok && !REGISTER_SEL) begin
         index_reg <= HOST_DATA_IN[4:0];
      end else if (write_ok) begin
         case (index_reg)
            lcd_timing_pkg::IDX_HTOTAL:    htotal_reg <= HOST_DATA_IN;
            lcd_timing_pkg::IDX_HDISP:     hdisp_reg  <= HOST_DATA_IN;
            lcd_timing_pkg::IDX_VTOTAL:    vtotal_reg <= HOST_DATA_IN;
            lcd_timing_pkg::IDX_VDISP:     vdisp_reg  <= HOST_DATA_IN;
            lcd_timing_pkg::IDX_MAXRAS:    maxras_reg <= HOST_DATA_IN[4:0];
            lcd_timing_pkg::IDX_CUR_START:
               cur_start_reg <= HOST_DATA_IN[4:0];
            lcd_timing_pkg::IDX_CUR_END:   cur_end_reg <= HOST_DATA_IN[4:0];
            lcd_timing_pkg::IDX_START_HI:  start_reg[15:8] <= HOST_DATA_IN;
            lcd_timing_pkg::IDX_START_LO:  start_reg[7:0]  <= HOST_DATA_IN;
            lcd_timing_pkg::IDX_CUR_HI:   cur_addr_reg[15:8] <= HOST_DATA_IN;
            lcd_timing_pkg::IDX_CUR_LO:   cur_addr_reg[7:0]  <= HOST_DATA_IN;
            lcd_timing_pkg::IDX_MODE:      mode_reg <= HOST_DATA_IN[4:0];
            default: ;                      // Other indices ignore writes
         endcase
      end
   end

   // Read multiplexer: cursor address, mode and live status
   always_comb begin
      case (index_reg)
         lcd_timing_pkg::IDX_CUR_HI: read_value = cur_addr_reg[15:8];
         lcd_timing_pkg::IDX_CUR_LO: read_value = cur_addr_reg[7:0];
         lcd_timing_pkg::IDX_MODE:   read_value = {3'h0, mode_reg};
         lcd_timing_pkg::IDX_STATUS:
            read_value = {3'h0, blink_phase_reg, AC_DRIVE,
                          FRAME_START_MARKER, DISPLAY_FETCH_WINDOW,
                          CURSOR_TIMING};
         default:                    read_value = 8'h00;
      endcase
   end

   // Read data stands one cycle after the strobe, driven only then
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         HOST_DATA_OUT  <= 8'h00;
         HOST_DATA_OE_N <= 1'b1;
      end else if (CE) begin
         HOST_DATA_OE_N <= !(read_ok && REGISTER_SEL);
         HOST_DATA_OUT  <= (read_ok && REGISTER_SEL) ? read_value : 8'h00;
      end
   end

   // ==========================================================
   // Effective mode
   // ==========================================================
   // Each mode is the pin ORed with its register bit
   assign mode_eff.disp    = DISPLAY_ON       | mode_reg.disp;
   assign mode_eff.blink   = BLINK_ALLOW      | mode_reg.blink;
   assign mode_eff.attr    = ATTRIBUTE_ENABLE | mode_reg.attr;
   assign mode_eff.graphic = GRAPHIC_SELECT   | mode_reg.graphic;
   assign mode_eff.wide    = WIDE_SELECT      | mode_reg.wide;

   // Easy mode swaps in fixed raster and cursor settings
   assign maxras_eff    = EASY_MODE ? lcd_timing_pkg::EASY_MAXRAS
                                    : maxras_reg;
   assign cur_start_eff = EASY_MODE ? lcd_timing_pkg::EASY_CUR_START
                                    : cur_start_reg;
   assign cur_end_eff   = EASY_MODE ? lcd_timing_pkg::EASY_CUR_END
                                    : cur_end_reg;
   assign vtotal_eff    = EASY_MODE ? lcd_timing_pkg::EASY_VTOTAL
                                    : vtotal_reg;

   // ==========================================================
   // Raster scan counters
   // ==========================================================
   assign line_end  = tick && (h_reg == htotal_reg);
   assign row_end   = line_end && (ras_reg == maxras_eff);
   assign frame_end = row_end && (row_reg == vtotal_eff);

   // Character, raster and row counters
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         h_reg   <= 8'h00;
         ras_reg <= 5'h00;
         row_reg <= 8'h00;
      end else if (tick) begin
         h_reg <= line_end ? 8'h00 : h_reg + 8'h01;
         if (line_end) begin
            ras_reg <= row_end ? 5'h00 : ras_reg + 5'h01;
         end
         if (frame_end) begin
            row_reg <= 8'h00;
         end else if (row_end) begin
            row_reg <= row_reg + 8'h01;
         end
      end
   end

   // Scan phase used to open the fetch window
   always_comb begin
      if (row_reg >= vdisp_reg) begin
         phase = lcd_timing_pkg::LP_VBLANK;
      end else if (h_reg >= hdisp_reg) begin
         phase = lcd_timing_pkg::LP_RETRACE;
      end else begin
         phase = lcd_timing_pkg::LP_DISPLAY;
      end
   end

   // Memory address walk; wide mode holds each address two char times
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ma_reg        <= 16'h0000;
         ma_row_reg    <= 16'h0000;
         wide_half_reg <= 1'b0;
      end else if (tick) begin
         if (frame_end) begin
            ma_reg        <= start_reg;
            ma_row_reg    <= start_reg;
            wide_half_reg <= 1'b0;
         end else if (row_end) begin
            ma_row_reg    <= ma_reg;     // Next row follows this one
            wide_half_reg <= 1'b0;
         end else if (line_end) begin
            ma_reg        <= ma_row_reg; // Repeat row for next raster
            wide_half_reg <= 1'b0;
         end else if (phase == lcd_timing_pkg::LP_DISPLAY) begin
            wide_half_reg <= mode_eff.wide && !wide_half_reg;
            if (!mode_eff.wide || wide_half_reg) begin
               ma_reg <= ma_reg + 16'h0001;
            end
         end
      end
   end
   assign DISPLAY_MEMORY_ADDR = ma_reg;
   assign RASTER_LINE_ADDR    = ras_reg;

   // ==========================================================
   // Fetch window, cursor and skew
   // ==========================================================
   assign win_now = (phase == lcd_timing_pkg::LP_DISPLAY)
                    && mode_eff.disp;
   assign cur_now = win_now && (ma_reg == cur_addr_reg)
                    && (ras_reg >= cur_start_eff)
                    && (ras_reg <= cur_end_eff);

   // Delay line, one stage per character time
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         win_dly_reg <= 2'h0;
         cur_dly_reg <= 2'h0;
      end else if (tick) begin
         win_dly_reg <= {win_dly_reg[0], win_now};
         cur_dly_reg <= {cur_dly_reg[0], cur_now};
      end
   end

   // Prohibited skew code falls back to no skew
   always_comb begin
      case ({SKEW_SELECT_HI, SKEW_SELECT_LO})
         lcd_timing_pkg::SKEW_ONE: begin
            win_skew = win_dly_reg[0];
            cur_skew = cur_dly_reg[0];
         end
         lcd_timing_pkg::SKEW_TWO: begin
            win_skew = win_dly_reg[1];
            cur_skew = cur_dly_reg[1];
         end
         default: begin
            win_skew = win_now;
            cur_skew = cur_now;
         end
      endcase
   end
   assign DISPLAY_FETCH_WINDOW = win_skew;
   assign CURSOR_TIMING        = cur_skew;

   // ==========================================================
   // Frame-rate signals
   // ==========================================================
   // Blink phase flips after every 32 frames; AC drive every frame
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         frame_cnt_reg   <= 5'h00;
         blink_phase_reg <= 1'b0;
         AC_DRIVE        <= 1'b0;
      end else if (frame_end) begin
         frame_cnt_reg <= frame_cnt_reg + 5'h01;
         if (frame_cnt_reg == lcd_timing_pkg::BLINK_LAST) begin
            blink_phase_reg <= !blink_phase_reg;
         end
         AC_DRIVE <= !AC_DRIVE;
      end
   end

   // Line latch at each line end; marker over the first line only
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         LINE_LATCH_CLOCK   <= 1'b0;
         FRAME_START_MARKER <= 1'b0;
      end else if (CE) begin
         LINE_LATCH_CLOCK   <= line_end;
         FRAME_START_MARKER <= (row_reg == 8'h00)
                               && (ras_reg == 5'h00);
      end
   end

   // ==========================================================
   // Pixel formation
   // ==========================================================
   // Character pixels: cursor bit, reverse and blink attributes
   always_comb begin
      dots = CHAR_DOT_DATA;
      if (mode_eff.attr && ATTRIBUTE_DATA[lcd_timing_pkg::ATTR_REVERSE]) begin
         dots = ~dots;
      end
      if (ATTRIBUTE_DATA[lcd_timing_pkg::ATTR_CURSOR]) begin
         dots = ~dots;
      end
      if (mode_eff.blink && blink_phase_reg
          && ATTRIBUTE_DATA[lcd_timing_pkg::ATTR_BLINK]) begin
         dots = 8'h00;
      end
   end

   assign wide8 = LARGE_SCREEN_SELECT || DUAL_SCREEN_SELECT;

   // Word and shift count for the coming memory cycle
   always_comb begin
      if (DUAL_SCREEN_SELECT) begin
         // Interleave: upper screen from low byte, lower from high
         load_word  = {CHAR_DOT_DATA[7:4], ATTRIBUTE_DATA[7:4],
                       CHAR_DOT_DATA[3:0], ATTRIBUTE_DATA[3:0]};
         load_count = lcd_timing_pkg::SHIFTS_TWO;
      end else if (mode_eff.graphic) begin
         load_word  = {CHAR_DOT_DATA, ATTRIBUTE_DATA};
         load_count = LARGE_SCREEN_SELECT ? lcd_timing_pkg::SHIFTS_TWO
                                          : lcd_timing_pkg::SHIFTS_FOUR;
      end else begin
         load_word  = {dots, 8'h00};
         load_count = LARGE_SCREEN_SELECT ? lcd_timing_pkg::SHIFTS_ONE
                                          : lcd_timing_pkg::SHIFTS_TWO;
      end
      if (!win_skew) begin
         load_word = 16'h0000;
      end
   end

   // ==========================================================
   // Panel shifter
   // ==========================================================
   // Word latched at cycle end, shifted out over the next cycle
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         sh_word_reg      <= 16'h0000;
         sh_left_reg      <= 3'h0;
         DATA_SHIFT_CLOCK <= 1'b0;
         UPPER_PANEL_DATA <= 4'h0;
         LOWER_PANEL_DATA <= 4'h0;
      end else if (CE) begin
         DATA_SHIFT_CLOCK <= (sh_left_reg != 3'h0);
         if (sh_left_reg != 3'h0) begin
            UPPER_PANEL_DATA <= sh_word_reg[15:12];
            LOWER_PANEL_DATA <= wide8 ? sh_word_reg[11:8]
                                      : 4'h0;
         end
         if (tick) begin
            sh_word_reg <= load_word;
            sh_left_reg <= load_count;
         end else if (sh_left_reg != 3'h0) begin
            sh_word_reg <= wide8 ? {sh_word_reg[7:0], 8'h00}
                                 : {sh_word_reg[11:0], 4'h0};
            sh_left_reg <= sh_left_reg - 3'h1;
         end
      end
   end

endmodule

// >>> logic/lcd_timing_pkg.sv
package lcd_timing_pkg;

   // ==========================================================
   // Memory-cycle divider
   // ==========================================================
   localparam logic [1:0] MCLK_LAST  = 2'h3;  // Last dot of a memory cycle
   localparam int         MCLK_BIT   = 1;     // Divider bit shown as MCLK

   // ==========================================================
   // Register indices (selected through the address register)
   // ==========================================================
   localparam logic [4:0] IDX_HTOTAL    = 5'h00;  // Char times per line - 1
   localparam logic [4:0] IDX_HDISP     = 5'h01;  // Displayed chars per line
   localparam logic [4:0] IDX_VTOTAL    = 5'h04;  // Rows per frame - 1
   localparam logic [4:0] IDX_VDISP     = 5'h06;  // Displayed rows
   localparam logic [4:0] IDX_MAXRAS    = 5'h09;  // Rasters per row - 1
   localparam logic [4:0] IDX_CUR_START = 5'h0a;  // Cursor first raster
   localparam logic [4:0] IDX_CUR_END   = 5'h0b;  // Cursor last raster
   localparam logic [4:0] IDX_START_HI  = 5'h0c;  // Start address high
   localparam logic [4:0] IDX_START_LO  = 5'h0d;  // Start address low
   localparam logic [4:0] IDX_CUR_HI    = 5'h0e;  // Cursor address high
   localparam logic [4:0] IDX_CUR_LO    = 5'h0f;  // Cursor address low
   localparam logic [4:0] IDX_MODE      = 5'h16;  // Mode control register
   localparam logic [4:0] IDX_STATUS    = 5'h1f;  // Live timing status

   // ==========================================================
   // Attribute byte fields
   // ==========================================================
   localparam int ATTR_REVERSE = 0;  // Reverse video
   localparam int ATTR_CURSOR  = 4;  // Cursor fed back from cursor output
   localparam int ATTR_BLINK   = 5;  // Blink request

   // ==========================================================
   // Blink and easy-mode presets
   // ==========================================================
   localparam logic [4:0] BLINK_LAST     = 5'h1f;  // 32 frames per phase
   localparam logic [4:0] EASY_MAXRAS    = 5'h07;  // 8 rasters per row
   localparam logic [4:0] EASY_CUR_START = 5'h07;  // Underline cursor
   localparam logic [4:0] EASY_CUR_END   = 5'h07;
   localparam logic [7:0] EASY_VTOTAL    = 8'h18;  // 25 rows per frame

   // ==========================================================
   // Skew selection and shift counts
   // ==========================================================
   localparam logic [1:0] SKEW_NONE = 2'h0;
   localparam logic [1:0] SKEW_ONE  = 2'h1;
   localparam logic [1:0] SKEW_TWO  = 2'h2;
   localparam logic [2:0] SHIFTS_ONE  = 3'h1;
   localparam logic [2:0] SHIFTS_TWO  = 3'h2;
   localparam logic [2:0] SHIFTS_FOUR = 3'h4;

   // ==========================================================
   // Types
   // ==========================================================
   // Mode control register layout, also the pin group layout
   typedef struct packed {
      logic wide;
      logic graphic;
      logic attr;
      logic blink;
      logic disp;
   } mode_t;

   // Panel data lanes
   typedef struct packed {
      logic [3:0] upper;
      logic [3:0] lower;
   } panel_t;

   // Horizontal/vertical position of the raster scan
   typedef enum logic [1:0] {
      LP_DISPLAY = 2'b00,
      LP_RETRACE = 2'b01,
      LP_VBLANK  = 2'b10
   } line_phase_t;

endpackage

// >>> tb/lcd_panel_timing_controller_checker.sv
`timescale 1ns/10ps
module lcd_panel_timing_controller_checker (
   // Clock and control
   input wire logic        CLK,
   input wire logic        RESETN,
   input wire logic        CE,
   // Host port
   input wire logic        CS_N,
   input wire logic        REGISTER_SEL,
   input wire logic        RD_STB,
   input wire logic [7:0]  HOST_DATA_OUT,
   input wire logic        HOST_DATA_OE_N,
   // Timing outputs
   input wire logic [15:0] DISPLAY_MEMORY_ADDR,
   input wire logic [4:0]  RASTER_LINE_ADDR,
   input wire logic        MCLK_OUT,
   input wire logic        LINE_LATCH_CLOCK
);
   // ==================
   // Sequences
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);
   // Accepted data read
   sequence rd_taken;
      RD_STB && !CS_N && REGISTER_SEL && CE;
   endsequence
   // Memory clock high for two dots
   sequence mclk_high;
      MCLK_OUT ##1 !MCLK_OUT;
   endsequence
   AST_MCLK_HALF: assert property (
      disable iff (!RESETN || !CE) $rose(MCLK_OUT) |=> mclk_high)
      else $error("mclk phase");
   AST_MCLK_PERIOD: assert property (
      disable iff (!RESETN || !CE) $rose(MCLK_OUT) |-> ##4 $rose(MCLK_OUT))
      else $error("mclk period");
   AST_RESET_CLEAR: assert property (
      disable iff (1'b0) !RESETN && $past(!RESETN, 2) |->
      DISPLAY_MEMORY_ADDR == 16'h0000 && RASTER_LINE_ADDR == 5'h00
      && HOST_DATA_OE_N && !MCLK_OUT) else $error("reset clear");
   AST_CS_IGNORE: assert property (
      CS_N && RD_STB |=> HOST_DATA_OE_N) else $error("cs ignored");
   AST_READ_ANSWER: assert property (
      rd_taken |=> !HOST_DATA_OE_N) else $error("read answer");
   AST_OE_CAUSE: assert property (
      !HOST_DATA_OE_N |-> $past(RD_STB && !CS_N && REGISTER_SEL && CE))
      else $error("stray drive");
   AST_BUS_IDLE: assert property (
      HOST_DATA_OE_N |-> HOST_DATA_OUT == 8'h00) else $error("bus idle");
   AST_LATCH_PULSE: assert property (
      disable iff (!RESETN || !CE) LINE_LATCH_CLOCK |=> !LINE_LATCH_CLOCK)
      else $error("latch pulse");
endmodule
bind lcd_panel_timing_controller lcd_panel_timing_controller_checker CHK (
   .CLK(CLK), .RESETN(RESETN), .CE(CE), .CS_N(CS_N),
   .REGISTER_SEL(REGISTER_SEL), .RD_STB(RD_STB),
   .HOST_DATA_OUT(HOST_DATA_OUT), .HOST_DATA_OE_N(HOST_DATA_OE_N),
   .DISPLAY_MEMORY_ADDR(DISPLAY_MEMORY_ADDR),
   .RASTER_LINE_ADDR(RASTER_LINE_ADDR), .MCLK_OUT(MCLK_OUT),
   .LINE_LATCH_CLOCK(LINE_LATCH_CLOCK));

// >>> tb/panel_side_model.sv
`timescale 1ns/10ps
module panel_side_model (
   // Clock and link
   input  wire logic        clk,
   input  wire logic [15:0] addr,
   input  wire logic        cursor,
   input  wire logic        latch,
   // Memory answer
   output logic      [7:0]  dots,
   output logic      [7:0]  attr,
   // Driver bookkeeping
   output int               latches
);
   // Pattern per address
   assign dots = addr[7:0] ^ 8'ha5;
   // Cursor fed back on attribute
   assign attr = {3'h0, cursor, 4'h0};
   initial latches = 0;
   // Count latch pulses
   always @(posedge clk) begin
      if (latch) begin
         latches <= latches + 1;
      end
   end
endmodule

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
   // ==================
   // Signals
   logic clk = 1'b0, rst_n = 1'b1, cs_n = 1'b1, rs = 1'b0, ce = 1'b1;
   logic wr = 1'b0, rd = 1'b0, oe_n, mclk, fetch, cur, llc, frame_start_marker, acd, dsc;
   logic [7:0]  din = 8'h00, dout, dots, attr;
   logic [3:0]  up, lo;
   logic [9:0]  pins = 10'h004;  // Display on only
   logic [15:0] ma;
   logic [4:0]  ra;
   int          latches, n_fail = 0, check_count = 0;
   always #50 clk = ~clk;
   lcd_panel_timing_controller DUT (.CLK(clk), .RESETN(rst_n), .CE(ce),
      .CS_N(cs_n), .REGISTER_SEL(rs), .WR_STB(wr), .RD_STB(rd),
      .HOST_DATA_IN(din), .HOST_DATA_OUT(dout), .HOST_DATA_OE_N(oe_n),
      .DISPLAY_MEMORY_ADDR(ma), .RASTER_LINE_ADDR(ra),
      .CHAR_DOT_DATA(dots), .ATTRIBUTE_DATA(attr), .MCLK_OUT(mclk),
      .DISPLAY_FETCH_WINDOW(fetch), .CURSOR_TIMING(cur),
      .SKEW_SELECT_LO(pins[0]), .SKEW_SELECT_HI(pins[1]),
      .DISPLAY_ON(pins[2]), .BLINK_ALLOW(pins[3]),
      .ATTRIBUTE_ENABLE(pins[4]), .GRAPHIC_SELECT(pins[5]),
      .WIDE_SELECT(pins[6]), .LARGE_SCREEN_SELECT(pins[7]),
      .DUAL_SCREEN_SELECT(pins[8]), .EASY_MODE(pins[9]),
      .UPPER_PANEL_DATA(up), .LOWER_PANEL_DATA(lo), .LINE_LATCH_CLOCK(llc),
      .DATA_SHIFT_CLOCK(dsc), .FRAME_START_MARKER(frame_start_marker), .AC_DRIVE(acd));
   panel_side_model PARTNER (.clk(clk), .addr(ma), .cursor(cur),
      .latch(llc), .dots(dots), .attr(attr), .latches(latches));
   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask
   // One-cycle write
   task automatic wreg(input logic s, input logic [7:0] d);
      @(posedge clk);
      cs_n <= 1'b0;
      rs <= s;
      din <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Index then data
   task automatic sel(input logic [7:0] i, input logic [7:0] d);
      wreg(1'b0, i);
      wreg(1'b1, d);
   endtask
   // Data read, c is chip select level
   task automatic rreg(input logic c, input logic [7:0] e);
      @(posedge clk);
      cs_n <= c;
      rs <= 1'b1;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      cs_n <= 1'b0;
      @(negedge clk);
      chk({15'h0, oe_n}, {15'h0, c});
      chk({8'h0, dout}, {8'h0, c ? 8'h00 : e});
   endtask
   task automatic t_regs;
      sel(8'h0e, 8'h3c);
      sel(8'h0f, 8'h5a);
      wreg(1'b0, 8'h0e);
      rreg(1'b0, 8'h3c);
      rreg(1'b1, 8'h3c);
      $display("regs done");
   endtask
   // Small raster: 8 chars, 4 shown, 2 rasters, 3 rows, 2 shown
   task automatic t_prog;
      logic [7:0] ix [12] = '{8'h00, 8'h01, 8'h04, 8'h06, 8'h09,
                              8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h16,
                              8'h0e, 8'h0f};
      logic [7:0] v [12] = '{8'h07, 8'h04, 8'h02, 8'h02, 8'h01,
                             8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'h02};
      for (int i = 0; i < 12; i++) begin
         sel(ix[i], v[i]);
      end
      wreg(1'b0, 8'h16);
      rreg(1'b0, 8'h00);
      $display("prog done");
   endtask
   task automatic t_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(ma, 16'h0000);
      chk({11'h0, ra}, 16'h0000);
      @(posedge clk);
      rst_n <= 1'b1;
      wreg(1'b0, 8'h0f);
      rreg(1'b0, 8'h02);
      $display("reset done");
   endtask
   task automatic t_mclk;
      time t0;
      logic [15:0] a;
      @(posedge mclk);
      t0 = $time;
      @(posedge mclk);
      chk(16'(($time - t0) / 100), 16'h0004);
      ce <= 1'b0;
      @(negedge clk);
      a = ma;
      repeat (8) @(negedge clk);
      chk({15'h0, mclk}, 16'h0001);
      chk(ma, a);
      @(posedge clk);
      ce <= 1'b1;
      $display("mclk done");
   endtask
   // One frame is 8 x 4 x 2 x 3 = 192 dots
   task automatic t_frame;
      int fw, fl, l0, fc, fs;
      logic a0;
      logic [3:0] ou, ol;
      fw = 0;
      fl = 0;
      fc = 0;
      fs = 0;
      ou = 4'h0;
      ol = 4'h0;
      @(posedge frame_start_marker);
      @(negedge clk);
      l0 = latches;
      a0 = acd;
      repeat (192) begin
         fw += int'(fetch);
         fl += int'(frame_start_marker);
         fc += int'(cur);
         fs += int'(dsc);
         ou |= up;
         ol |= lo;
         @(negedge clk);
      end
      chk(16'(fc), 16'h0004);
      chk(16'(fs), 16'h0060);
      chk({12'h0, ou}, 16'h000f);
      chk({12'h0, ol}, 16'h0000);
      chk({15'h0, frame_start_marker}, 16'h0001);
      chk(16'(fl), 16'h0020);
      chk(16'(fw), 16'h0040);
      chk(16'(latches - l0), 16'h0006);
      chk({15'h0, acd}, {15'h0, ~a0});
      $display("frame done");
   endtask
   // Display pin low, mode register bit keeps it on
   task automatic t_mode;
      int n;
      n = 0;
      @(posedge clk);
      pins[2] <= 1'b0;
      sel(8'h16, 8'h01);
      repeat (192) begin
         @(negedge clk);
         n += int'(fetch);
      end
      chk(16'(n), 16'h0040);
      $display("mode done");
   endtask
   task automatic results;
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_prog();
      t_reset();
      t_mclk();
      t_frame();
      t_mode();
      results();
   end
   // Watchdog
   initial begin
      #2000000;
      n_fail++;
      results();
   end
endmodule
